// ---- bench/ipsm_assertions.sv ----
/* checker for the ipsm_top ports
   assumes one clock, reset synchronous active low */
`timescale 1ns/10ps
`include "ipsm_regs.vh"
module ipsm_checker #(parameter NUM_PINS = 182) (
  input wire clk_sys,
  input wire rst_b,
  input wire [`IPSM_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire comparator_one_output,
  input wire [NUM_PINS-1:0] remap_pins,
  input wire can_receive_line,
  input wire pwm_sync_input_one,
  input wire deadtime_comp_input_one
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // quiet spans: no write while the source holds still
  sequence calm_comp;
    (!reg_wr && $stable(comparator_one_output)) [*7];
  endsequence
  sequence calm_pin;
    (!reg_wr && $stable(remap_pins[181])) [*7];
  endsequence
  sequence wr_at(a, lo, c);
    reg_wr && reg_addr == a && (lo ? reg_wdata[7:0] : reg_wdata[15:8]) == c;
  endsequence
  AST_CAN_HI_ZERO: assert property (
    reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:8] == 8'h00) else $error("can high byte set");
  AST_SYNC_LO_ZERO: assert property (
    reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:0] == 8'h00) else $error("sync low byte set");
  AST_DTCMP_LO_ZERO: assert property (
    reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:0] == 8'h00) else $error("dtcmp low byte set");
  AST_CAN_GROUND: assert property (
    wr_at(4'h0, 1, 8'h00) ##1 !reg_wr [*2] |=> !can_receive_line) else $error("can not ground");
  AST_DTCMP_GROUND: assert property (
    wr_at(4'h2, 0, 8'h00) ##1 !reg_wr [*2] |=> !deadtime_comp_input_one)
    else $error("dtcmp not ground");
  AST_CAN_COMP: assert property (
    wr_at(4'h0, 1, 8'h01) ##1 calm_comp |-> can_receive_line == comparator_one_output)
    else $error("can not comparator");
  AST_SYNC_PIN: assert property (
    wr_at(4'h1, 0, 8'hB5) ##1 calm_pin |-> pwm_sync_input_one == remap_pins[181])
    else $error("sync not pin");
  AST_DTCMP_COMP: assert property (
    wr_at(4'h2, 0, 8'h01) ##1 calm_comp |-> deadtime_comp_input_one == comparator_one_output)
    else $error("dtcmp not comparator");
endmodule // ipsm_checker
bind ipsm_top ipsm_checker #(.NUM_PINS(NUM_PINS)) u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .comparator_one_output(comparator_one_output),
  .remap_pins(remap_pins), .can_receive_line(can_receive_line),
  .pwm_sync_input_one(pwm_sync_input_one),
  .deadtime_comp_input_one(deadtime_comp_input_one));

// ---- bench/tb_ipsm_top.sv ----
/* testbench for ipsm_top
   assumes ipsm_regs.vh on the include path */
`timescale 1ns/10ps
`include "ipsm_regs.vh"
module tb_ipsm_top;
  reg clk_sys, rst_b, reg_wr, reg_rd, comparator_one_output;
  reg [3:0] reg_addr;
  reg [15:0] reg_wdata;
  reg [181:0] remap_pins;
  wire [15:0] reg_rdata;
  wire can_receive_line, pwm_sync_input_one, deadtime_comp_input_one;
  integer mismatches = 0;
  integer checked = 0;
  ipsm_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .comparator_one_output(comparator_one_output), .remap_pins(remap_pins),
    .can_receive_line(can_receive_line), .pwm_sync_input_one(pwm_sync_input_one),
    .deadtime_comp_input_one(deadtime_comp_input_one));
  ////////////////////////////////////////
  // compare, then realign to the next edge
  task chk(input [15:0] got, input [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
    @(posedge clk_sys);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // long enough for the synchroniser and mux register
  task wt;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  task reset_values;
    wt; chk({can_receive_line, pwm_sync_input_one, deadtime_comp_input_one}, 16'h0000);
    rd(`IPSM_OFS_CAN_SEL, 16'h0000);
    rd(`IPSM_OFS_SYNC_SEL, 16'h0000);
    rd(`IPSM_OFS_DTCMP_SEL, 16'h0000);
  endtask
  task can_route;
    wr(`IPSM_OFS_CAN_SEL, 16'hFF01);
    wt; chk(can_receive_line, 16'h0000);
    comparator_one_output <= 1'b1;
    wt; chk(can_receive_line, 16'h0001);
    rd(`IPSM_OFS_CAN_SEL, 16'h0001);
    wr(`IPSM_OFS_CAN_SEL, 16'hFF00);
    wt; chk(can_receive_line, 16'h0000);
  endtask
  task sync_route;
    wr(`IPSM_OFS_SYNC_SEL, 16'hB5FF);
    wt; chk(pwm_sync_input_one, 16'h0000);
    remap_pins <= {1'b1, 181'h0};
    wt; chk(pwm_sync_input_one, 16'h0001);
    rd(`IPSM_OFS_SYNC_SEL, 16'hB500);
    remap_pins <= 182'h80;
    wr(`IPSM_OFS_SYNC_SEL, 16'h0700);
    wt; chk(pwm_sync_input_one, 16'h0001);
  endtask
  task dt_route;
    wr(`IPSM_OFS_DTCMP_SEL, 16'h01AB);
    wt; chk(deadtime_comp_input_one, 16'h0001);
    rd(`IPSM_OFS_DTCMP_SEL, 16'h0100);
    rd(`IPSM_OFS_STATUS, 16'h0006);
    wr(`IPSM_OFS_DTCMP_SEL, 16'h0000);
    wt; chk(deadtime_comp_input_one, 16'h0000);
  endtask
  task unmapped;
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
  endtask
  task give_verdict;
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // clock, reset and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    comparator_one_output = 1'b0;
    remap_pins = 182'h0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    reset_values;
    can_route;
    sync_route;
    dt_route;
    unmapped;
    give_verdict;
  end
  // watchdog well beyond the expected run
  initial begin
    #8000;
    mismatches = mismatches + 1;
    give_verdict;
  end
endmodule // tb_ipsm_top

// ---- hdl/ipsm_regs.vh ----
/*
  Register offsets, field positions, reset values and source codes for the
  input pin select mux. Assumes word-indexed 16-bit registers on a plain port.
*/
`ifndef IPSM_REGS_VH
`define IPSM_REGS_VH

// register indexes on the plain register port
`define IPSM_ADDR_W 4
`define IPSM_OFS_CAN_SEL 4'h0
`define IPSM_OFS_SYNC_SEL 4'h1
`define IPSM_OFS_DTCMP_SEL 4'h2
`define IPSM_OFS_STATUS 4'h3

// field positions
`define IPSM_CAN_FIELD_LSB 0
`define IPSM_SYNC_FIELD_LSB 8
`define IPSM_DTCMP_FIELD_LSB 8
`define IPSM_STAT_CAN_BIT 0
`define IPSM_STAT_SYNC_BIT 1
`define IPSM_STAT_DTCMP_BIT 2

// reset values
`define IPSM_SEL_RESET 8'h00
`define IPSM_RDATA_RESET 16'h0000

// source codes
`define IPSM_CODE_GROUND 8'h00
`define IPSM_CODE_COMP_ONE 8'h01
`define IPSM_CODE_FIRST_PIN 8'h02
`define IPSM_CODE_LAST_PIN 8'hB5

`endif

// ---- hdl/ipsm_source_mux.v ----
/*
  One peripheral input source selector: ground, comparator one or a
  remappable pin chosen by an eight-bit code, result registered.
  Assumes all source levels are already in the clk_sys domain.
*/
`timescale 1ns/10ps
`include "ipsm_regs.vh"

module ipsm_source_mux #(
  parameter NUM_PINS = 182
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [7:0] source_sel,
  input wire comparator_one_output,
  input wire [NUM_PINS-1:0] remap_pins,
  output reg routed
);

  reg next_routed;

  ////////////////////////////////////////////////////////////////////////////
  // decode the code into a source level; unused codes read ground
  always @* begin
    next_routed = 1'b0;
    if (source_sel == `IPSM_CODE_GROUND) begin
      next_routed = 1'b0;
    end else if (source_sel == `IPSM_CODE_COMP_ONE) begin
      next_routed = comparator_one_output;
    end else if ((source_sel >= `IPSM_CODE_FIRST_PIN) &&
                 (source_sel <= `IPSM_CODE_LAST_PIN) &&
                 ({24'h000000, source_sel} < NUM_PINS)) begin
      next_routed = remap_pins[source_sel];
    end
  end

  // registered output
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      routed <= 1'b0;
    end else begin
      routed <= next_routed;
    end
  end

endmodule // ipsm_source_mux

// ---- hdl/ipsm_sync.v ----
/*
  Three-flop synchroniser bank for inputs from outside the clock domain.
  A new level is accepted only once the second and third stages agree.
  Assumes clk_sys and a synchronous active-low reset.
*/
`timescale 1ns/10ps

module ipsm_sync #(
  parameter WIDTH = 1
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] clean_out
);

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
      reg stage1;
      reg stage2;
      reg stage3;
      reg clean;
      // first stage feeds only the second; filter looks at stages two and three
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
          clean <= 1'b0;
        end else begin
          stage1 <= async_in[g];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            clean <= stage3;
          end
        end
      end
      assign clean_out[g] = clean;
    end
  endgenerate

endmodule // ipsm_sync

// ---- hdl/ipsm_top.v ----
/*
  Input pin select mux: routes the CAN receive line, PWM sync input 1 and
  PWM dead-time compensation input 1 from software-chosen sources.
  Assumes a plain register port on clk_sys with read data one cycle later,
  and asynchronous pin and comparator levels.

*/
`timescale 1ns/10ps
`include "ipsm_regs.vh"

module ipsm_top #(
  parameter NUM_PINS = 182
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [`IPSM_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire comparator_one_output,
  input wire [NUM_PINS-1:0] remap_pins,
  output wire can_receive_line,
  output wire pwm_sync_input_one,
  output wire deadtime_comp_input_one
);

  reg [7:0] can_receive_source_field;
  reg [7:0] pwm_sync_source_field;
  reg [7:0] deadtime_comp_source_field;
  reg [15:0] next_rdata;
  wire comp_clean;
  wire [NUM_PINS-1:0] pins_clean;
  wire can_routed;
  wire sync_routed;
  wire dtcmp_routed;

  ////////////////////////////////////////////////////////////////////////////
  // selector fields, writable from the register port
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      can_receive_source_field <= `IPSM_SEL_RESET;
      pwm_sync_source_field <= `IPSM_SEL_RESET;
      deadtime_comp_source_field <= `IPSM_SEL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `IPSM_OFS_CAN_SEL: begin
          can_receive_source_field <= reg_wdata[`IPSM_CAN_FIELD_LSB +: 8];
        end
        `IPSM_OFS_SYNC_SEL: begin
          pwm_sync_source_field <= reg_wdata[`IPSM_SYNC_FIELD_LSB +: 8];
        end
        `IPSM_OFS_DTCMP_SEL: begin
          deadtime_comp_source_field <= reg_wdata[`IPSM_DTCMP_FIELD_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data decode; unimplemented bytes and unmapped indexes read zero
  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `IPSM_OFS_CAN_SEL: begin
        next_rdata = {8'h00, can_receive_source_field};
      end
      `IPSM_OFS_SYNC_SEL: begin
        next_rdata = {pwm_sync_source_field, 8'h00};
      end
      `IPSM_OFS_DTCMP_SEL: begin
        next_rdata = {deadtime_comp_source_field, 8'h00};
      end
      `IPSM_OFS_STATUS: begin
        next_rdata[`IPSM_STAT_CAN_BIT] = can_routed;
        next_rdata[`IPSM_STAT_SYNC_BIT] = sync_routed;
        next_rdata[`IPSM_STAT_DTCMP_BIT] = dtcmp_routed;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // read data stand in the cycle after the strobe only
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= `IPSM_RDATA_RESET;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= `IPSM_RDATA_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bring comparator and remap pins into the clock domain
  ipsm_sync #(
    .WIDTH(NUM_PINS + 1)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in({comparator_one_output, remap_pins}),
    .clean_out({comp_clean, pins_clean})
  );

  ////////////////////////////////////////////////////////////////////////////
  // one selector per peripheral input, all with the same encoding
  ipsm_source_mux #(
    .NUM_PINS(NUM_PINS)
  ) u_can_mux (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .source_sel(can_receive_source_field),
    .comparator_one_output(comp_clean),
    .remap_pins(pins_clean),
    .routed(can_routed)
  );

  ipsm_source_mux #(
    .NUM_PINS(NUM_PINS)
  ) u_sync_mux (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .source_sel(pwm_sync_source_field),
    .comparator_one_output(comp_clean),
    .remap_pins(pins_clean),
    .routed(sync_routed)
  );

  ipsm_source_mux #(
    .NUM_PINS(NUM_PINS)
  ) u_dtcmp_mux (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .source_sel(deadtime_comp_source_field),
    .comparator_one_output(comp_clean),
    .remap_pins(pins_clean),
    .routed(dtcmp_routed)
  );

  // routed levels come straight from the selector flip-flops
  assign can_receive_line = can_routed;
  assign pwm_sync_input_one = sync_routed;
  assign deadtime_comp_input_one = dtcmp_routed;

endmodule // ipsm_top
